// File: rtcs_top.sv
// Two-wire serial slave front end of the real-time clock
//
// Notes on behaviour
// RULE1: Answer only after START and address D0h
// RULE2: Eight bytes: seconds through year, then trim
// RULE3: Power failure aborts access, clears pointer
// RULE4: Writes stay blocked for recovery interval
// RULE5: Master starts only on an idle bus
// RULE6: Data changes with clock high are conditions
// RULE7: Data falling with clock high is START
// RULE8: Data rising with clock high is STOP
// RULE9: Eight data bits plus ninth acknowledge bit
// RULE10: Receiver holds data low over acknowledge
// RULE11: Released line after master withholds acknowledge
// RULE12: Byte after write address loads pointer
// RULE13: Store data, then advance on acknowledge
// RULE14: Acknowledge address, word address, every data
// RULE15: Repeated START read sends addressed byte
// RULE16: Pointer advances on acknowledge; send until STOP
// RULE17: Freeze user copy while pointer below 07h
// RULE18: Plain read starts from last pointer
// RULE19: Halt bit stops counting; clear restarts
// RULE20: Century flag toggles only when enabled
// RULE21: Day, date, month, year byte layout
// RULE22: Clock bytes singly or burst; trim alone (here a burst runs on from year into trim, then wraps to seconds)
// RULE23: Clock byte write resets divider chain
// RULE24: Trim byte holds sign and magnitude
// RULE25: Foreign address ignored until next START
`timescale 1ns/1ps
`include "rtcs_regs.svh"

module rtcs_top
	import rtcs_pkg::*;
#(
	parameter int SECOND_CYCLES = `RTCS_SECOND_S * `RTCS_CLK_HZ,
	parameter int REC_CYCLES    = `RTCS_REC_TIME_US * `RTCS_CLK_MHZ
)
(
	input  wire logic       CLOCK_I,
	input  wire logic       RST_I,
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE_O,
	input  wire logic       POWER_FAIL_I,
	output logic            WRITE_LOCKED_O,
	output logic            CLOCK_FROZEN_O,
	output logic            OSC_HALTED_O,
	output logic [7:0]      TRIM_O
);

	localparam int REC_W = $clog2(REC_CYCLES + 1);

	generate
		if (REC_CYCLES < 1)
		begin : g_bad
			$error("REC_CYCLES must be at least 1");
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed
	{
		rtcs_state_type  state;
		rtcs_kind_type   kind;
		logic [3:0]      cnt;
		logic [7:0]      shift;
		logic [2:0]      ptr;
		logic            rw;
		logic            acked;
		logic            sda_drive;
		logic [6:0][7:0] user;
		logic [7:0]      trim;
		logic [REC_W-1:0] lockout;
		logic            frozen;
	} rtcs_top_type;

	rtcs_top_type    cur;
	rtcs_top_type    next_cur;

	logic            start;
	logic            stop;
	logic            scl_rise;
	logic            scl_fall;
	logic [6:0][7:0] cal_time;
	logic            cal_wr_en;
	logic [7:0]      cal_wr_data;
	logic            freeze;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Unused bits of the clock bytes read back as zero; the trim byte reads back unmasked
	function automatic logic [7:0] field_mask(input logic [2:0] idx);
		unique case (idx)
			`RTCS_REG_DAY:   return 8'h07;
			`RTCS_REG_DATE:  return 8'h3f;
			`RTCS_REG_MONTH: return 8'h1f;
			`RTCS_REG_MINUTES: return 8'h7f;
			`RTCS_REG_SECONDS, `RTCS_REG_HOURS, `RTCS_REG_YEAR, `RTCS_REG_TRIM: return 8'hff;
		endcase
	endfunction

	function automatic logic [7:0] read_byte(input rtcs_top_type s, input logic [2:0] idx);
		if (idx == `RTCS_REG_TRIM)
			return s.trim; // see RULE22 see RULE24
		else
			return s.user[idx] & field_mask(idx); // see RULE2 see RULE21
	endfunction

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	rtcs_conditions u_conditions
	(
		.clk_i      (CLOCK_I),
		.rst_i      (RST_I),
		.scl_i      (SCL_I),
		.sda_i      (SDA_I),
		.start_o    (start),
		.stop_o     (stop),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall)
	);

	rtcs_calendar #(
		.SECOND_CYCLES (SECOND_CYCLES)
	) u_calendar
	(
		.clk_i      (CLOCK_I),
		.rst_i      (RST_I),
		.wr_en_i    (cal_wr_en),
		.wr_index_i (cur.ptr),
		.wr_data_i  (cal_wr_data),
		.time_o     (cal_time)
	);

	// ----------------------------------------------------------------
	// Freeze of the user copy
	// ----------------------------------------------------------------
	// Frozen while addressed at a clock byte; STOP or pointer 07h releases it
	assign freeze = (cur.state != BUS_IDLE) && (cur.kind != KIND_ADDR)
		&& (cur.ptr != `RTCS_REG_TRIM); // see RULE17

	// ----------------------------------------------------------------
	// Bus engine
	// ----------------------------------------------------------------
	always_comb
	begin
		next_cur    = cur;
		cal_wr_en   = 1'b0;
		cal_wr_data = cur.shift;
		next_cur.frozen = freeze;
		if (!freeze)
		begin
			next_cur.user = cal_time; // see RULE17
		end

		if (POWER_FAIL_I)
		begin
			// Everything on the bus is ignored until supply returns and the recovery lockout has run out
			next_cur.state     = BUS_IDLE; // see RULE3
			next_cur.kind      = KIND_ADDR;
			next_cur.ptr       = `RTCS_REG_SECONDS;
			next_cur.sda_drive = 1'b0;
			next_cur.lockout   = REC_W'(REC_CYCLES);
		end
		else if (cur.lockout != '0)
		begin
			next_cur.state     = BUS_IDLE; // see RULE4
			next_cur.kind      = KIND_ADDR;
			next_cur.sda_drive = 1'b0;
			next_cur.lockout   = cur.lockout - REC_W'(1);
		end
		else if (start)
		begin
			// Also serves as repeated START; pointer is kept
			next_cur.state     = RECV_BITS; // see RULE1 see RULE15
			next_cur.kind      = KIND_ADDR;
			next_cur.cnt       = 4'h0;
			next_cur.sda_drive = 1'b0;
		end
		else if (stop)
		begin
			next_cur.state     = BUS_IDLE; // see RULE8
			next_cur.kind      = KIND_ADDR;
			next_cur.sda_drive = 1'b0;
		end
		else
		begin
			unique case (cur.state)
				BUS_IDLE:
				begin
					next_cur.sda_drive = 1'b0; // see RULE25
				end

				RECV_BITS:
				begin
					if (scl_rise)
					begin
						next_cur.shift = {cur.shift[6:0], SDA_I}; // see RULE9
						next_cur.cnt   = cur.cnt + 4'h1;
					end
					else if (scl_fall && cur.cnt == `RTCS_BYTE_BITS)
					begin
						next_cur.state     = RECV_ACK;
						next_cur.sda_drive = 1'b1; // see RULE14 see RULE10
						unique case (cur.kind)
							KIND_ADDR:
							begin
								if (cur.shift[7:1] != 7'(`RTCS_BUS_ADDR >> 1))
								begin
									next_cur.state     = BUS_IDLE; // see RULE25 see RULE1
									next_cur.sda_drive = 1'b0;
								end
								next_cur.rw = cur.shift[0];
							end
							KIND_WORD:
							begin
								next_cur.ptr = cur.shift[2:0]; // see RULE12
							end
							KIND_DATA:
							begin
								if (cur.ptr == `RTCS_REG_TRIM)
								begin
									next_cur.trim = cur.shift; // see RULE24
								end
								else
								begin
									cal_wr_en   = 1'b1; // see RULE13 see RULE23
									cal_wr_data = cur.shift & field_mask(cur.ptr);
								end
							end
						endcase
					end
				end

				RECV_ACK:
				begin
					if (scl_rise && cur.kind == KIND_DATA)
					begin
						next_cur.ptr = cur.ptr + 3'h1; // see RULE13
					end
					else if (scl_fall)
					begin
						next_cur.cnt       = 4'h0;
						next_cur.sda_drive = 1'b0;
						next_cur.state     = RECV_BITS;
						if (cur.kind == KIND_ADDR && cur.rw)
						begin
							// Read starts where the pointer was left
							next_cur.state     = SEND_BITS; // see RULE15 see RULE18
							next_cur.shift     = read_byte(cur, cur.ptr);
							next_cur.sda_drive = ~next_cur.shift[7];
						end
						else if (cur.kind == KIND_ADDR)
						begin
							next_cur.kind = KIND_WORD;
						end
						else
						begin
							next_cur.kind = KIND_DATA;
						end
					end
				end

				SEND_BITS:
				begin
					next_cur.kind = KIND_DATA;
					if (scl_fall)
					begin
						if (cur.cnt == `RTCS_LAST_TX_BIT)
						begin
							next_cur.state     = SEND_ACK;
							next_cur.sda_drive = 1'b0;
						end
						else
						begin
							next_cur.shift     = {cur.shift[6:0], 1'b0};
							next_cur.sda_drive = ~cur.shift[6];
							next_cur.cnt       = cur.cnt + 4'h1;
						end
					end
				end

				SEND_ACK:
				begin
					if (scl_rise)
					begin
						next_cur.acked = ~SDA_I;
						if (!SDA_I)
						begin
							next_cur.ptr = cur.ptr + 3'h1; // see RULE16
						end
					end
					else if (scl_fall)
					begin
						next_cur.cnt = 4'h0;
						if (cur.acked)
						begin
							next_cur.state     = SEND_BITS; // see RULE16
							next_cur.shift     = read_byte(cur, cur.ptr);
							next_cur.sda_drive = ~next_cur.shift[7];
						end
						else
						begin
							// Line left released so the master can STOP
							next_cur.state     = BUS_IDLE; // see RULE11
							next_cur.sda_drive = 1'b0;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset counts as power-up, so the recovery lockout runs first
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			cur.state     <= BUS_IDLE;
			cur.kind      <= KIND_ADDR;
			cur.cnt       <= 4'h0;
			cur.shift     <= 8'h00;
			cur.ptr       <= `RTCS_REG_SECONDS;
			cur.rw        <= 1'b0;
			cur.acked     <= 1'b0;
			cur.sda_drive <= 1'b0;
			cur.user      <= {`RTCS_TIME_RESET, `RTCS_DAY_RESET, `RTCS_DAY_RESET, `RTCS_DAY_RESET,
				`RTCS_TIME_RESET, `RTCS_TIME_RESET, `RTCS_TIME_RESET};
			cur.trim      <= `RTCS_TRIM_RESET;
			cur.lockout   <= REC_W'(REC_CYCLES); // see RULE4
			cur.frozen    <= 1'b0;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open drain: only ever pulls low
	assign SDA_O          = 1'b0;
	assign SDA_OE_O       = cur.sda_drive;
	assign WRITE_LOCKED_O = cur.lockout != '0;
	assign CLOCK_FROZEN_O = cur.frozen;
	assign OSC_HALTED_O   = cur.user[`RTCS_REG_SECONDS][`RTCS_HALT_BIT];
	assign TRIM_O         = cur.trim;

endmodule

// File: rtcs_regs.svh
// Register offsets, field positions, reset values and timing for the serial clock slave
`ifndef RTCS_REGS_SVH
`define RTCS_REGS_SVH

// ----------------------------------------------------------------
// Bus address and byte framing
// ----------------------------------------------------------------
`define RTCS_BUS_ADDR       8'hd0
`define RTCS_BYTE_BITS      4'h8
`define RTCS_LAST_TX_BIT    4'h7

// ----------------------------------------------------------------
// Word addresses
// ----------------------------------------------------------------
`define RTCS_REG_SECONDS    3'h0
`define RTCS_REG_MINUTES    3'h1
`define RTCS_REG_HOURS      3'h2
`define RTCS_REG_DAY        3'h3
`define RTCS_REG_DATE       3'h4
`define RTCS_REG_MONTH      3'h5
`define RTCS_REG_YEAR       3'h6
`define RTCS_REG_TRIM       3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTCS_HALT_BIT       7
`define RTCS_CENT_EN_BIT    7
`define RTCS_CENT_FLAG_BIT  6
`define RTCS_TRIM_SIGN_BIT  5
`define RTCS_TRIM_MAG_MSB   4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTCS_TIME_RESET     8'h00
`define RTCS_DAY_RESET      8'h01
`define RTCS_TRIM_RESET     8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RTCS_CLK_HZ         20_000_000
`define RTCS_CLK_MHZ        20
`define RTCS_SECOND_S       1
`define RTCS_REC_TIME_US    1000

`endif

// File: rtcs_pkg.sv
// Types shared by the serial clock slave modules
package rtcs_pkg;

	// ----------------------------------------------------------------
	// Bus engine states and byte kinds
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {BUS_IDLE, RECV_BITS, RECV_ACK, SEND_BITS, SEND_ACK} rtcs_state_type;
	typedef enum logic [1:0] {KIND_ADDR, KIND_WORD, KIND_DATA} rtcs_kind_type;

	// ----------------------------------------------------------------
	// Line edge detector state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic scl_q;
		logic sda_q;
	} rtcs_lines_type;

endpackage

// File: rtcs_conditions.sv
// Bus line edge and START/STOP detector
`timescale 1ns/1ps
`include "rtcs_regs.svh"

module rtcs_conditions
	import rtcs_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      start_o,
	output logic      stop_o,
	output logic      scl_rise_o,
	output logic      scl_fall_o
);

	rtcs_lines_type cur;
	rtcs_lines_type next_cur;

	// ----------------------------------------------------------------
	// Edge decode
	// ----------------------------------------------------------------
	always_comb
	begin
		next_cur.scl_q = scl_i;
		next_cur.sda_q = sda_i;
		start_o    = cur.scl_q & scl_i & cur.sda_q & ~sda_i; // see RULE7 see RULE6
		stop_o     = cur.scl_q & scl_i & ~cur.sda_q & sda_i; // see RULE8 see RULE6
		scl_rise_o = ~cur.scl_q & scl_i;
		scl_fall_o = cur.scl_q & ~scl_i;
	end

	// Idle lines are high, so reset never fakes a condition
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cur <= '{scl_q: 1'b1, sda_q: 1'b1};
		end
		else
		begin
			cur <= next_cur;
		end
	end

endmodule

// File: rtcs_calendar.sv
// Internal BCD time and date counter chain
`timescale 1ns/1ps
`include "rtcs_regs.svh"

module rtcs_calendar
	import rtcs_pkg::*;
#(
	parameter int SECOND_CYCLES = `RTCS_SECOND_S * `RTCS_CLK_HZ
)
(
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            wr_en_i,
	input  wire logic [2:0]      wr_index_i,
	input  wire logic [7:0]      wr_data_i,
	output logic      [6:0][7:0] time_o
);

	localparam int DIV_W = $clog2(SECOND_CYCLES);

	generate
		if (SECOND_CYCLES < 2)
		begin : g_bad
			$error("SECOND_CYCLES must be at least 2");
		end
	endgenerate

	typedef struct packed
	{
		logic [DIV_W-1:0] div;
		logic [6:0][7:0]  tb;
	} rtcs_cal_type;

	rtcs_cal_type cur;
	rtcs_cal_type next_cur;

	// ----------------------------------------------------------------
	// BCD helpers
	// ----------------------------------------------------------------
	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top, input logic [7:0] low);
		if (v >= top)
			return {1'b1, low};
		else if (v[3:0] >= 4'h9)
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			return {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] month_end(input logic [7:0] month, input logic [7:0] year);
		if (month == 8'h02)
			return (year[1:0] == {year[4], 1'b0}) ? 8'h29 : 8'h28;
		else if (month == 8'h04 || month == 8'h06 || month == 8'h09 || month == 8'h11)
			return 8'h30;
		else
			return 8'h31;
	endfunction

	// ----------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [8:0] s;
		s = '0;
		next_cur = cur;
		if (wr_en_i)
		begin
			next_cur.tb[wr_index_i] = wr_data_i;
			next_cur.div = '0; // see RULE23
		end
		else if (!cur.tb[`RTCS_REG_SECONDS][`RTCS_HALT_BIT]) // see RULE19
		begin
			if (cur.div == DIV_W'(SECOND_CYCLES - 1))
			begin
				next_cur.div = '0;
				s = bcd_step({1'b0, cur.tb[0][6:0]}, 8'h59, 8'h00);
				next_cur.tb[0][6:0] = s[6:0];
				if (s[8])
				begin
					s = bcd_step({1'b0, cur.tb[1][6:0]}, 8'h59, 8'h00);
					next_cur.tb[1] = {1'b0, s[6:0]};
				end
				if (s[8])
				begin
					s = bcd_step({2'b00, cur.tb[2][5:0]}, 8'h23, 8'h00);
					next_cur.tb[2][5:0] = s[5:0];
				end
				if (s[8])
				begin
					s = bcd_step({5'b0, cur.tb[3][2:0]}, 8'h07, 8'h01); // see RULE21
					next_cur.tb[3] = {5'b0, s[2:0]};
					s = bcd_step(cur.tb[4], month_end(cur.tb[5], cur.tb[6]), 8'h01);
					next_cur.tb[4] = s[7:0];
				end
				if (s[8])
				begin
					s = bcd_step(cur.tb[5], 8'h12, 8'h01);
					next_cur.tb[5] = s[7:0];
				end
				if (s[8])
				begin
					s = bcd_step(cur.tb[6], 8'h99, 8'h00);
					next_cur.tb[6] = s[7:0];
				end
				if (s[8] && cur.tb[2][`RTCS_CENT_EN_BIT]) // see RULE20
				begin
					next_cur.tb[2][`RTCS_CENT_FLAG_BIT] = ~cur.tb[2][`RTCS_CENT_FLAG_BIT];
				end
			end
			else
			begin
				next_cur.div = cur.div + DIV_W'(1);
			end
		end
		time_o = cur.tb;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cur.div <= '0;
			cur.tb  <= {`RTCS_TIME_RESET, `RTCS_DAY_RESET, `RTCS_DAY_RESET, `RTCS_DAY_RESET,
				`RTCS_TIME_RESET, `RTCS_TIME_RESET, `RTCS_TIME_RESET};
		end
		else
		begin
			cur <= next_cur;
		end
	end

endmodule

// File: rtcs_master_model.sv
// Behavioural two-wire bus master for the serial clock slave
`timescale 1ns/1ps

module rtcs_master_model
(
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// --------
	// Line phases
	// --------
	// Four clocks a phase, well above the two-cycle minimum
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic phase();
		repeat (4) @(negedge clk_i);
	endtask

	// Data moves only with SCL low; sampled late in the high phase
	task automatic clock_bit(input logic b, output logic seen);
		sda_low_o = ~b;
		phase();
		scl_o = 1'b1;
		phase();
		seen = sda_i;
		scl_o = 1'b0;
		@(negedge clk_i);
	endtask

	task automatic start();
		sda_low_o = 1'b0;
		phase();
		scl_o = 1'b1;
		phase();
		sda_low_o = 1'b1;
		phase();
		scl_o = 1'b0;
		@(negedge clk_i);
	endtask

	task automatic stop();
		sda_low_o = 1'b1;
		phase();
		scl_o = 1'b1;
		phase();
		sda_low_o = 1'b0;
		phase();
	endtask

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clock_bit(d[i], s);
		clock_bit(1'b1, s);
		ack = ~s;
	endtask

	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clock_bit(1'b1, d[i]);
		clock_bit(~ack, s);
	endtask
endmodule

// File: rtcs_top_asserts.sv
// Port-level checker for the serial clock slave
`timescale 1ns/1ps

module rtcs_top_asserts
#(
	parameter int REC_CYCLES = 20000
)
(
	input wire logic       CLOCK_I,
	input wire logic       RST_I,
	input wire logic       SCL_I,
	input wire logic       SDA_I,
	input wire logic       SDA_O,
	input wire logic       SDA_OE_O,
	input wire logic       POWER_FAIL_I,
	input wire logic       WRITE_LOCKED_O,
	input wire logic       CLOCK_FROZEN_O,
	input wire logic       OSC_HALTED_O,
	input wire logic [7:0] TRIM_O
);
	// --------
	// Helpers
	// --------
	int lock_cnt;

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);

	// Counter, since the lockout is far longer than a repetition may be
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
			lock_cnt <= 0;
		else if (WRITE_LOCKED_O && !POWER_FAIL_I)
			lock_cnt <= lock_cnt + 1;
		else
			lock_cnt <= 0;
	end

	sequence stop_seen;
		SCL_I && $past(SCL_I) && SDA_I && !$past(SDA_I) && !POWER_FAIL_I && !WRITE_LOCKED_O;
	endsequence

	sequence drive_held;
		SDA_OE_O [*2];
	endsequence

	// --------
	// Assertions
	// --------
	a_oe_after_fall: assert property ($rose(SDA_OE_O) |-> !$past(SCL_I) && $past(SCL_I, 2))
		else $error("data drive began without a clock fall");
	a_ack_held_high: assert property ($rose(SCL_I) && SDA_OE_O && !POWER_FAIL_I |=> drive_held)
		else $error("data drive dropped while clock high");
	a_oe_scl_low: assert property ($changed(SDA_OE_O) && !POWER_FAIL_I && !$past(POWER_FAIL_I) |-> !$past(SCL_I))
		else $error("data drive changed with clock high");
	a_pf_quiet: assert property (POWER_FAIL_I && $past(POWER_FAIL_I) |-> !SDA_OE_O)
		else $error("data driven during power fail");
	a_locked_quiet: assert property (WRITE_LOCKED_O && $past(WRITE_LOCKED_O) |-> !SDA_OE_O)
		else $error("data driven during lockout");
	a_trim_guarded: assert property ($changed(TRIM_O) |-> !$past(WRITE_LOCKED_O) && !$past(POWER_FAIL_I))
		else $error("trim byte changed while inputs ignored");
	a_unfreeze_stop: assert property (stop_seen |-> ##[1:3] !CLOCK_FROZEN_O)
		else $error("clock copy still frozen after stop");
	a_lock_after_reset: assert property ($fell(RST_I) |-> WRITE_LOCKED_O [*8])
		else $error("lockout missing after reset");
	a_lock_bounded: assert property (lock_cnt <= REC_CYCLES + 2)
		else $error("lockout lasted too long");
endmodule

bind rtcs_top rtcs_top_asserts #(.REC_CYCLES(REC_CYCLES)) u_asserts
(
	.CLOCK_I        (CLOCK_I),
	.RST_I          (RST_I),
	.SCL_I          (SCL_I),
	.SDA_I          (SDA_I),
	.SDA_O          (SDA_O),
	.SDA_OE_O       (SDA_OE_O),
	.POWER_FAIL_I   (POWER_FAIL_I),
	.WRITE_LOCKED_O (WRITE_LOCKED_O),
	.CLOCK_FROZEN_O (CLOCK_FROZEN_O),
	.OSC_HALTED_O   (OSC_HALTED_O),
	.TRIM_O         (TRIM_O)
);

// File: testbench.sv
// Self-checking testbench for the serial clock slave
`timescale 1ns/1ps

module testbench;
	localparam int REC = 60;
	logic       clk;
	logic       rst;
	logic       pf;
	wire        scl;
	wire        m_low;
	wire        sda;
	wire        sda_o;
	wire        oe;
	wire        locked;
	wire        frozen;
	wire        halted;
	wire  [7:0] trim;
	int         mismatches;
	int         num_checks;
	logic [7:0] write_regs [7];
	logic [7:0] expect_regs [8];

	rtcs_top #(.SECOND_CYCLES(100000), .REC_CYCLES(REC)) u_dut
	(
		.CLOCK_I        (clk),
		.RST_I          (rst),
		.SCL_I          (scl),
		.SDA_I          (sda),
		.SDA_O          (sda_o),
		.SDA_OE_O       (oe),
		.POWER_FAIL_I   (pf),
		.WRITE_LOCKED_O (locked),
		.CLOCK_FROZEN_O (frozen),
		.OSC_HALTED_O   (halted),
		.TRIM_O         (trim)
	);

	rtcs_master_model u_master
	(
		.clk_i     (clk),
		.sda_i     (sda),
		.scl_o     (scl),
		.sda_low_o (m_low)
	);

	// Pulled-up wire: either party may pull it low
	assign sda = ~(m_low | (oe & ~sda_o));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// --------
	// Shared tasks
	// --------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic send(input string what, input logic [7:0] v, input logic exp_ack);
		logic ack;
		u_master.wr_byte(v, ack);
		check(what, {7'h00, ack}, {7'h00, exp_ack});
	endtask

	task automatic set_ptr(input logic [7:0] p);
		u_master.start();
		send("write address", 8'hd0, 1'b1);
		send("word address", p, 1'b1);
	endtask

	task automatic read_run(input int first, input int n);
		logic [7:0] d;
		u_master.start();
		send("read address", 8'hd1, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			u_master.rd_byte(i < n - 1, d);
			check("register", d, expect_regs[first + i]);
			if (i < n - 1)
				check("freeze", {7'h00, frozen}, {7'h00, first + i != 6});
		end
		check("release", {7'h00, oe}, 8'h00);
		check("data value", {7'h00, sda_o}, 8'h00);
		u_master.stop();
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// --------
	// Tests
	// --------
	initial
	begin
		rst = 1'b1;
		pf = 1'b0;
		mismatches = 0;
		num_checks = 0;
		write_regs = '{8'h30, 8'h45, 8'hc2, 8'hfb, 8'h15, 8'h11, 8'h99};
		expect_regs = '{8'h30, 8'h45, 8'hc2, 8'h03, 8'h15, 8'h11, 8'h99, 8'h2a};
		repeat (3) @(negedge clk);
		check("lock in reset", {7'h00, locked}, 8'h01);
		check("trim in reset", trim, 8'h00);
		rst = 1'b0;
		u_master.start();
		send("early address", 8'hd0, 1'b0);
		u_master.stop();
		check("lock over", {7'h00, locked}, 8'h00);
		set_ptr(8'h07);
		send("trim data", 8'h2a, 1'b1);
		u_master.stop();
		check("trim", trim, 8'h2a);
		set_ptr(8'h00);
		for (int i = 0; i < 7; i++)
			send("clock data", write_regs[i], 1'b1);
		u_master.stop();
		set_ptr(8'h00);
		read_run(0, 8);
		repeat (3) @(negedge clk);
		check("unfrozen", {7'h00, frozen}, 8'h00);
		read_run(7, 1);
		u_master.start();
		send("foreign address", 8'ha0, 1'b0);
		send("no restart", 8'hd0, 1'b0);
		u_master.stop();
		for (int h = 1; h >= 0; h--)
		begin
			set_ptr(8'h00);
			send("halt byte", {h[0], 7'h30}, 1'b1);
			u_master.stop();
			repeat (3) @(negedge clk);
			check("halted", {7'h00, halted}, {7'h00, h[0]});
		end
		set_ptr(8'h03);
		pf = 1'b1;
		send("data in power fail", 8'h05, 1'b0);
		u_master.stop();
		pf = 1'b0;
		repeat (2) @(negedge clk);
		check("lock after power fail", {7'h00, locked}, 8'h01);
		repeat (REC + 4) @(negedge clk);
		read_run(0, 4);
		print_verdict();
	end

	// Whole run is near 3700 clocks; over five times that means a hang
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("mismatch watchdog expected end seen hang");
		print_verdict();
	end
endmodule
